// ### core/frsp_row_sequencer.sv
/*
  Flash row self-program sequencer: register port, unlock key checker,
  32 write latches, row erase and row program sequencing, processor stall.
  Assumes all inputs synchronous to sys_clk, a flash array outside that takes
  one erase strobe or one word write per cycle, and a processor that obeys
  the forced-nop and stall outputs.
*/
// Functional notes
// - programming never erases the row first
// - erase unit is exactly one row
// - one program writes at most 32 words
// - row from upper ten bits, latch from low five
// - program touches only the selected row
// - latches go blank after every program
// - latches go blank after every erase
// - unloaded latches program the blank value
// - latch-only mode just loads the addressed latch
// - normal mode loads addressed latch, programs row
// - load and program need the unlock sequence
// - erase needs erase select, enable, config clear
// - two forced nops then stall during erase
// - go bits set by software, cleared by hardware
// - reset during write sets aborted flag
// - unlock key port reads as zero
// - erase or program stalls processor about 2 ms
`timescale 1ns/1ps
module frsp_row_sequencer
  import frsp_pkg::*;
#(
  parameter int OP_WAIT_CYCLES = OP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic por_reset,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic cpu_force_nop,
  output logic cpu_stall,
  output logic flash_erase,
  output logic [ROW_W-1:0] flash_row,
  output logic flash_word_we,
  output logic [ROW_W+IDX_W-1:0] flash_word_addr,
  output logic [WORD_W-1:0] flash_word_data,
  output logic busy
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] addr_low_reg;
  logic [HIGH_W-1:0] addr_high_reg;
  logic [DATA_W-1:0] data_low_reg;
  logic [DATA_HIGH_W-1:0] data_high_reg;
  logic read_go_reg;
  logic program_go_reg;
  logic enable_reg;
  logic aborted_reg;
  logic erase_sel_reg;
  logic latch_only_reg;
  logic cfg_sel_reg;
  logic write_marker_reg;
  logic released_reg;
  frsp_key_t key_reg;
  frsp_key_t key_next;
  frsp_seq_t seq_reg;
  frsp_seq_t seq_next;
  logic op_erase_reg;
  logic op_latch_only_reg;
  logic [1:0] nop_cnt_reg;
  logic [IDX_W-1:0] stream_idx_reg;
  logic [WAIT_W-1:0] wait_cnt_reg;
  logic [WORD_W-1:0] latch_mem [LATCH_COUNT];
  logic [DATA_W-1:0] rdata_reg;
  logic nop_out_reg;
  logic stall_out_reg;
  logic erase_out_reg;
  logic [ROW_W-1:0] row_out_reg;
  logic word_we_reg;
  logic [ROW_W+IDX_W-1:0] word_addr_reg;
  logic [WORD_W-1:0] word_data_reg;
  logic busy_reg;

  logic access;
  logic ctrl_wr;
  logic go_wr;
  logic trigger;
  logic load_latch;
  logic blank_latches;
  logic wait_done;
  logic [ROW_W-1:0] sel_row;
  logic [IDX_W-1:0] sel_idx;
  logic [WORD_W-1:0] sel_word;

  assign access = reg_wr | reg_rd;
  assign ctrl_wr = reg_wr & hit(reg_addr, OFF_CONTROL);
  assign go_wr = ctrl_wr & reg_wdata[BIT_PROGRAM_GO];
  // the go write counts only straight after both keys and with the sequencer idle
  assign trigger = (key_reg == KEY_ARMED) & go_wr & (seq_reg == SEQ_IDLE)
                 & enable_reg & ~cfg_sel_reg;
  assign sel_row = {addr_high_reg, addr_low_reg[7:5]};
  assign sel_idx = addr_low_reg[IDX_W-1:0];
  assign sel_word = {data_high_reg, data_low_reg};
  // an erase never loads a latch; every other accepted trigger loads one
  assign load_latch = trigger & ~erase_sel_reg;
  assign blank_latches = (seq_reg == SEQ_BLANK);
  assign wait_done = (wait_cnt_reg == WAIT_W'(OP_WAIT_CYCLES - 1));

  // ----------------------------------------------------------------------
  // address and data holding registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      addr_low_reg <= ADDR_RESET;
      addr_high_reg <= ADDR_RESET[HIGH_W-1:0];
      data_low_reg <= DATA_RESET;
      data_high_reg <= DATA_RESET[DATA_HIGH_W-1:0];
    end else if (ce && reg_wr) begin
      if (hit(reg_addr, OFF_ADDR_LOW)) begin
        addr_low_reg <= reg_wdata;
      end
      if (hit(reg_addr, OFF_ADDR_HIGH)) begin
        addr_high_reg <= reg_wdata[HIGH_W-1:0];
      end
      if (hit(reg_addr, OFF_DATA_LOW)) begin
        data_low_reg <= reg_wdata;
      end
      if (hit(reg_addr, OFF_DATA_HIGH)) begin
        data_high_reg <= reg_wdata[DATA_HIGH_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // control bits that software owns
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enable_reg <= CONTROL_RESET[BIT_SELF_PROGRAM_ENABLE];
      erase_sel_reg <= CONTROL_RESET[BIT_ROW_ERASE_SELECT];
      latch_only_reg <= CONTROL_RESET[BIT_LATCH_ONLY_SELECT];
      cfg_sel_reg <= CONTROL_RESET[BIT_CONFIG_SPACE_SELECT];
    end else if (ce && ctrl_wr) begin
      enable_reg <= reg_wdata[BIT_SELF_PROGRAM_ENABLE];
      erase_sel_reg <= reg_wdata[BIT_ROW_ERASE_SELECT];
      latch_only_reg <= reg_wdata[BIT_LATCH_ONLY_SELECT];
      cfg_sel_reg <= reg_wdata[BIT_CONFIG_SPACE_SELECT];
    end
  end

  // ----------------------------------------------------------------------
  // go bits: software may only set them, hardware clears them
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      read_go_reg <= CONTROL_RESET[BIT_READ_GO];
      program_go_reg <= CONTROL_RESET[BIT_PROGRAM_GO];
    end else if (ce) begin
      // reads are not modelled here, so the read finishes in one cycle
      read_go_reg <= ctrl_wr & reg_wdata[BIT_READ_GO];
      if (trigger) begin
        program_go_reg <= 1'b1;
      end else if (seq_next == SEQ_IDLE && seq_reg != SEQ_IDLE) begin
        program_go_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // aborted-write detection, kept across the ordinary reset
  // ----------------------------------------------------------------------
  // the marker lives on the power-on reset only, so a warm reset in the
  // middle of a write leaves it standing for the check made while released_reg is low
  always_ff @(posedge sys_clk or posedge por_reset) begin
    if (por_reset) begin
      write_marker_reg <= 1'b0;
      aborted_reg <= CONTROL_RESET[BIT_ABORTED_PROGRAM_FLAG];
    end else if (ce) begin
      if (!released_reg) begin
        write_marker_reg <= 1'b0;
      end else if (seq_next == SEQ_ERASE || seq_next == SEQ_STREAM) begin
        write_marker_reg <= 1'b1;
      end else if (blank_latches) begin
        write_marker_reg <= 1'b0;
      end
      if (!released_reg && write_marker_reg) begin
        aborted_reg <= 1'b1;
      end else if (ctrl_wr && !reg_wdata[BIT_ABORTED_PROGRAM_FLAG]) begin
        aborted_reg <= 1'b0;
      end
    end
  end

  // first enabled cycle after the ordinary reset is released
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      released_reg <= 1'b0;
    end else if (ce) begin
      released_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // unlock key checker
  // ----------------------------------------------------------------------
  // any bus access out of order drops back to idle, so an interrupt that
  // touches a register between the keys cancels the whole sequence
  always_comb begin
    key_next = key_reg;
    case (key_reg)
      KEY_IDLE: begin
        if (reg_wr && hit(reg_addr, OFF_UNLOCK_KEY) && reg_wdata == KEY_FIRST) begin
          key_next = KEY_GOT_FIRST;
        end
      end
      KEY_GOT_FIRST: begin
        if (reg_wr && hit(reg_addr, OFF_UNLOCK_KEY) && reg_wdata == KEY_SECOND) begin
          key_next = KEY_ARMED;
        end else if (access) begin
          key_next = KEY_IDLE;
        end
      end
      KEY_ARMED: begin
        if (access) begin
          key_next = KEY_IDLE;
        end
      end
      default: begin
        key_next = KEY_IDLE;
      end
    endcase
    if (seq_reg != SEQ_IDLE) begin
      key_next = KEY_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      key_reg <= KEY_IDLE;
    end else if (ce) begin
      key_reg <= key_next;
    end
  end

  // ----------------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE: begin
        if (trigger) begin
          seq_next = SEQ_NOP;
        end
      end
      SEQ_NOP: begin
        if (nop_cnt_reg == NOP_LAST) begin
          if (op_erase_reg) begin
            seq_next = SEQ_ERASE;
          end else if (op_latch_only_reg) begin
            seq_next = SEQ_IDLE;
          end else begin
            seq_next = SEQ_STREAM;
          end
        end
      end
      SEQ_ERASE: begin
        seq_next = SEQ_WAIT;
      end
      SEQ_STREAM: begin
        if (stream_idx_reg == LAST_IDX) begin
          seq_next = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (wait_done) begin
          seq_next = SEQ_BLANK;
        end
      end
      SEQ_BLANK: begin
        seq_next = SEQ_IDLE;
      end
      default: begin
        seq_next = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seq_reg <= SEQ_IDLE;
      op_erase_reg <= 1'b0;
      op_latch_only_reg <= 1'b0;
      nop_cnt_reg <= 2'h0;
      stream_idx_reg <= '0;
      wait_cnt_reg <= '0;
      row_out_reg <= '0;
    end else if (ce) begin
      seq_reg <= seq_next;
      if (trigger) begin
        op_erase_reg <= erase_sel_reg;
        op_latch_only_reg <= latch_only_reg;
        row_out_reg <= sel_row;
        nop_cnt_reg <= 2'h0;
      end else if (seq_reg == SEQ_NOP) begin
        nop_cnt_reg <= nop_cnt_reg + 2'h1;
      end
      stream_idx_reg <= (seq_reg == SEQ_STREAM) ? stream_idx_reg + 5'h01 : '0;
      wait_cnt_reg <= (seq_reg == SEQ_WAIT) ? wait_cnt_reg + 17'h00001 : '0;
    end
  end

  // ----------------------------------------------------------------------
  // write latches
  // ----------------------------------------------------------------------
  // each latch resets blank and goes blank again after any erase or program,
  // so a row write after a partial load leaves the rest erased-looking
  for (genvar i = 0; i < LATCH_COUNT; i++) begin : g_latch
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        latch_mem[i] <= BLANK_WORD;
      end else if (ce) begin
        if (blank_latches) begin
          latch_mem[i] <= BLANK_WORD;
        end else if (load_latch && sel_idx == IDX_W'(i)) begin
          latch_mem[i] <= sel_word;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // flash-side outputs
  // ----------------------------------------------------------------------
  // words leave one per cycle; the row part of the address is the captured
  // row, so no word can land outside it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      erase_out_reg <= 1'b0;
      word_we_reg <= 1'b0;
      word_addr_reg <= '0;
      word_data_reg <= BLANK_WORD;
    end else if (ce) begin
      erase_out_reg <= (seq_next == SEQ_ERASE);
      word_we_reg <= (seq_reg == SEQ_STREAM);
      word_addr_reg <= {row_out_reg, stream_idx_reg};
      word_data_reg <= latch_mem[stream_idx_reg];
    end
  end

  // ----------------------------------------------------------------------
  // processor control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      nop_out_reg <= 1'b0;
      stall_out_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (ce) begin
      nop_out_reg <= (seq_next == SEQ_NOP);
      stall_out_reg <= (seq_next == SEQ_ERASE) || (seq_next == SEQ_STREAM)
                    || (seq_next == SEQ_WAIT) || (seq_next == SEQ_BLANK);
      busy_reg <= (seq_next != SEQ_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFF_ADDR_LOW: rdata_reg <= addr_low_reg;
          OFF_ADDR_HIGH: rdata_reg <= {1'b0, addr_high_reg};
          OFF_DATA_LOW: rdata_reg <= data_low_reg;
          OFF_DATA_HIGH: rdata_reg <= {2'b00, data_high_reg};
          OFF_CONTROL: rdata_reg <= {1'b0, cfg_sel_reg, latch_only_reg, erase_sel_reg,
                                     aborted_reg, enable_reg, program_go_reg, read_go_reg};
          OFF_UNLOCK_KEY: rdata_reg <= '0;
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign cpu_force_nop = nop_out_reg;
  assign cpu_stall = stall_out_reg;
  assign flash_erase = erase_out_reg;
  assign flash_row = row_out_reg;
  assign flash_word_we = word_we_reg;
  assign flash_word_addr = word_addr_reg;
  assign flash_word_data = word_data_reg;
  assign busy = busy_reg;

endmodule

// ### core/frsp_pkg.sv
/*
  Package for the flash row self-program sequencer: register offsets, control
  field positions, reset values, key bytes, latch geometry, timing and the
  state enumerations.
  Assumes a 25 MHz system clock and an 8-bit register port.
*/
package frsp_pkg;

  // ----------------------------------------------------------------------
  // register port geometry and offsets
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_ADDR_LOW = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_ADDR_HIGH = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_DATA_LOW = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_DATA_HIGH = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_UNLOCK_KEY = 3'h5;

  // ----------------------------------------------------------------------
  // self_program_control field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BIT_READ_GO = 0;
  localparam int BIT_PROGRAM_GO = 1;
  localparam int BIT_SELF_PROGRAM_ENABLE = 2;
  localparam int BIT_ABORTED_PROGRAM_FLAG = 3;
  localparam int BIT_ROW_ERASE_SELECT = 4;
  localparam int BIT_LATCH_ONLY_SELECT = 5;
  localparam int BIT_CONFIG_SPACE_SELECT = 6;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // key bytes and latch geometry
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] KEY_FIRST = 8'h55;
  localparam logic [DATA_W-1:0] KEY_SECOND = 8'haa;
  localparam int LATCH_COUNT = 32;
  localparam int IDX_W = 5;
  localparam int ROW_W = 10;
  localparam int WORD_W = 14;
  localparam int HIGH_W = 7;
  localparam int DATA_HIGH_W = 6;
  localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3fff;
  localparam logic [IDX_W-1:0] LAST_IDX = 5'h1f;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 25000;
  localparam int FORCED_NOPS = 2;
  localparam logic [1:0] NOP_LAST = 2'h1;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = (OP_TIME_US * SYS_CLK_KHZ) / 1000;
  localparam int WAIT_W = 17;

  // ----------------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} frsp_key_t;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_NOP, SEQ_ERASE, SEQ_STREAM, SEQ_WAIT, SEQ_BLANK
  } frsp_seq_t;

endpackage

// ### bench/frsp_row_props.sv
/*
  Port checker for the flash row self-program sequencer.
  Bound from tb_top; sees only the sequencer ports, ce assumed high.
*/
`timescale 1ns/1ps
module frsp_row_props
  import frsp_pkg::*;
#(
  parameter int OP_WAIT_CYCLES = OP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic por_reset,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic cpu_force_nop,
  input wire logic cpu_stall,
  input wire logic flash_erase,
  input wire logic [ROW_W-1:0] flash_row,
  input wire logic flash_word_we,
  input wire logic [ROW_W+IDX_W-1:0] flash_word_addr,
  input wire logic [WORD_W-1:0] flash_word_data,
  input wire logic busy
);
  // ----------------------------------------------------------------------
  // helper: length of the current word burst
  // ----------------------------------------------------------------------
  logic [5:0] run_reg;
  // a counter, because a 32-long repetition would choke the tools
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      run_reg <= 6'h00;
    end else if (ce) begin
      run_reg <= flash_word_we ? run_reg + 6'h01 : 6'h00;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset || por_reset);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  key_reads_zero_a: assert property (reg_rd && reg_addr == OFF_UNLOCK_KEY |=>
    reg_rdata == 8'h00) else $error("key port read not zero");
  nop_pair_a: assert property ($rose(cpu_force_nop) |=> cpu_force_nop ##1
    !cpu_force_nop) else $error("forced nop not two cycles");
  erase_after_nops_a: assert property (flash_erase |-> $past(cpu_force_nop)
    && !cpu_force_nop && cpu_stall) else $error("erase not after nops");
  erase_single_a: assert property (flash_erase |=> !flash_erase)
    else $error("erase pulse too long");
  prog_no_erase_a: assert property (flash_word_we |-> !flash_erase && cpu_stall
    && busy) else $error("word write without stall or with erase");
  run_max_a: assert property (flash_word_we |-> run_reg < 6'h20)
    else $error("more than 32 words");
  run_full_a: assert property ($fell(flash_word_we) |-> run_reg == 6'h20)
    else $error("burst shorter than 32 words");
  row_match_a: assert property (flash_word_we |->
    flash_word_addr[14:5] == flash_row) else $error("word outside row");
  idx_start_a: assert property ($rose(flash_word_we) |->
    flash_word_addr[4:0] == 5'h00) else $error("burst not from latch 0");
  idx_step_a: assert property (flash_word_we && $past(flash_word_we) |->
    flash_word_addr == $past(flash_word_addr) + 15'h0001) else $error("latch order");
  unlock_order_a: assert property ($rose(cpu_force_nop) |-> $past(reg_wr)
    && $past(reg_addr) == OFF_CONTROL && $past(reg_wdata[BIT_PROGRAM_GO])
    && $past(reg_addr, 2) == OFF_UNLOCK_KEY && $past(reg_wdata, 2) == KEY_SECOND
    && $past(reg_wdata, 3) == KEY_FIRST) else $error("go without key pair");

  // main scenarios reached
  cover property (flash_erase);
  cover property ($fell(flash_word_we));
  cover property (cpu_force_nop ##2 !busy);
endmodule

// ### bench/tb_top.sv
/*
  Self-checking bench for the row sequencer: register tasks, latch model
  and a result queue. Assumes the operation wait shortened to 8 cycles.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import frsp_pkg::*;
  localparam int WAITC = 8;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic por_reset = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic cpu_force_nop, cpu_stall, flash_erase, flash_word_we, busy;
  logic [ROW_W-1:0] flash_row;
  logic [ROW_W+IDX_W-1:0] flash_word_addr;
  logic [WORD_W-1:0] flash_word_data;
  logic [35:0] exp_q[$];
  logic [WORD_W-1:0] lat[LATCH_COUNT];
  int fails = 0;
  int n_compared = 0;

  always #20 sys_clk = ~sys_clk;

  frsp_row_sequencer #(.OP_WAIT_CYCLES(WAITC)) dut (
    .sys_clk(sys_clk), .reset(reset), .por_reset(por_reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_force_nop(cpu_force_nop), .cpu_stall(cpu_stall),
    .flash_erase(flash_erase), .flash_row(flash_row), .flash_word_we(flash_word_we),
    .flash_word_addr(flash_word_addr), .flash_word_data(flash_word_data), .busy(busy)
  );

  // ----------------------------------------------------------------------
  // result watcher: every result takes the oldest note
  // ----------------------------------------------------------------------
  task automatic take(input logic [35:0] obs);
    logic [35:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
    `CHK(obs, e)
  endtask
  always @(posedge sys_clk) begin
    rd_q <= reg_rd;
    if (rd_q) take({4'h1, 24'h0, reg_rdata});
    if (flash_word_we === 1'b1) take({4'h2, 3'h0, flash_word_addr, flash_word_data});
    if (flash_erase === 1'b1) take({4'h3, 22'h0, flash_row});
  end

  // ----------------------------------------------------------------------
  // register port tasks; each step raises one strobe and drops the other, idle drops both
  // ----------------------------------------------------------------------
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back({4'h1, 24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  // bounded wait for the sequencer to go idle
  task automatic settle();
    int k;
    idle(3);
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge sys_clk);
    idle(2);
  endtask
  // mode bits go in first: the go write acts on the mode already held
  task automatic unlock(input logic [7:0] ctl);
    wr(OFF_CONTROL, ctl);
    // keys and go back to back, nothing may slip in between
    wr(OFF_UNLOCK_KEY, KEY_FIRST);
    wr(OFF_UNLOCK_KEY, KEY_SECOND);
    wr(OFF_CONTROL, ctl | 8'h02);
  endtask
  task automatic put(input logic [9:0] row, input logic [4:0] idx, input logic [13:0] d);
    wr(OFF_ADDR_HIGH, {1'b0, row[9:3]});
    wr(OFF_ADDR_LOW, {row[2:0], idx});
    wr(OFF_DATA_LOW, d[7:0]);
    wr(OFF_DATA_HIGH, {2'b00, d[13:8]});
  endtask
  task automatic load(input logic [9:0] row, input logic [4:0] idx, input logic [7:0] ctl);
    logic [13:0] d;
    d = 14'($urandom);
    put(row, idx, d);
    unlock(ctl);
    if (ctl[BIT_SELF_PROGRAM_ENABLE]) lat[idx] = d;
    settle();
  endtask
  // final latch plus row program; words noted before they can appear
  task automatic prog(input logic [9:0] row);
    int i;
    logic [13:0] d;
    d = 14'($urandom);
    put(row, LAST_IDX, d);
    lat[LAST_IDX] = d;
    unlock(8'h04);
    rd(OFF_CONTROL, 8'h06);
    for (i = 0; i < LATCH_COUNT; i++) begin
      exp_q.push_back({4'h2, 3'h0, row, i[4:0], lat[i]});
      lat[i] = BLANK_WORD;
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim();
  end

  initial begin
    int i;
    logic [9:0] row;
    void'($urandom(32'h440969d1));
    for (i = 0; i < LATCH_COUNT; i++) lat[i] = BLANK_WORD;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    por_reset <= 1'b0;
    @(posedge sys_clk);
    // reset values, key port and unmapped reads, go without keys
    rd(OFF_CONTROL, CONTROL_RESET);
    wr(OFF_UNLOCK_KEY, KEY_FIRST);
    rd(OFF_UNLOCK_KEY, 8'h00);
    rd(3'h6, 8'h00);
    wr(OFF_CONTROL, 8'h06);
    rd(OFF_CONTROL, 8'h04);
    row = 10'($urandom);
    // load with enable clear must leave latches alone
    load(row, 5'h03, 8'h20);
    rd(OFF_CONTROL, 8'h20);
    // a read between the keys breaks the sequence
    put(row, 5'h02, 14'h1234);
    wr(OFF_CONTROL, 8'h24);
    wr(OFF_UNLOCK_KEY, KEY_FIRST);
    rd(OFF_ADDR_LOW, {row[2:0], 5'h02});
    wr(OFF_UNLOCK_KEY, KEY_SECOND);
    wr(OFF_CONTROL, 8'h26);
    settle();
    rd(OFF_CONTROL, 8'h24);
    // config space selected refuses the go; read-go clears itself
    unlock(8'h45);
    rd(OFF_CONTROL, 8'h45);
    rd(OFF_CONTROL, 8'h44);
    // latch-only loads, then final latch and program
    for (i = 0; i < 5; i++) load(row, 5'(i * 7), 8'h24);
    prog(row);
    settle();
    prog(row + 10'h001);
    settle();
    // a loaded latch is wiped by an erase
    row = 10'($urandom);
    load(row, 5'h09, 8'h24);
    put(row, 5'h11, 14'h0000);
    unlock(8'h14);
    rd(OFF_CONTROL, 8'h16);
    exp_q.push_back({4'h3, 22'h0, row});
    for (i = 0; i < LATCH_COUNT; i++) lat[i] = BLANK_WORD;
    settle();
    prog(row);
    settle();
    // reset while the row write is still waiting
    prog(row ^ 10'h2a5);
    idle(38);
    reset <= 1'b1;
    idle(3);
    reset <= 1'b0;
    idle(2);
    rd(OFF_CONTROL, 8'h08);
    wr(OFF_CONTROL, 8'h00);
    rd(OFF_CONTROL, 8'h00);
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(OFF_ADDR_LOW, 8'h5a);
    ce <= 1'b1;
    rd(OFF_ADDR_LOW, ADDR_RESET);
    idle(3);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule

bind frsp_row_sequencer frsp_row_props #(.OP_WAIT_CYCLES(OP_WAIT_CYCLES)) u_props (
  .sys_clk(sys_clk), .reset(reset), .por_reset(por_reset), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cpu_force_nop(cpu_force_nop), .cpu_stall(cpu_stall),
  .flash_erase(flash_erase), .flash_row(flash_row), .flash_word_we(flash_word_we),
  .flash_word_addr(flash_word_addr), .flash_word_data(flash_word_data), .busy(busy)
);
